// >>> rtl/tm2_edge_if.sv
`timescale 1ns/1ps
interface tm2_edge_if;
    logic strobe;
    logic fall;
    logic level;
    modport sampler (input strobe, output fall, output level);
    modport user    (output strobe, input fall, input level);
endinterface : tm2_edge_if

// >>> rtl/tm2_edge_sampler.sv
`timescale 1ns/1ps
module tm2_edge_sampler
    import tm2_pkg::*;
(
    // clock and reset
    input  wire logic   mclk,
    input  wire logic   rst_n,
    // pin and sample port
    input  wire logic   pin,
    tm2_edge_if.sampler edge_port
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic smp;
        logic fall;
    } tm2_smp_type;

    tm2_smp_type st_r;
    tm2_smp_type st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = pin;
        st_nxt.s2   = st_r.s1;
        st_nxt.fall = 1'b0;
        if (edge_port.strobe) begin
            st_nxt.smp  = st_r.s2;
            st_nxt.fall = st_r.smp & ~st_r.s2;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign edge_port.fall  = st_r.fall;
    assign edge_port.level = st_r.smp;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_FALL_AFTER_STROBE: assert property (
        @(posedge mclk) disable iff (!rst_n)
        st_r.fall |-> $past(edge_port.strobe))
        else $error("fall without a sample strobe");

    AST_FALL_IS_HIGH_LOW: assert property (
        @(posedge mclk) disable iff (!rst_n)
        st_r.fall |-> !st_r.smp && $past(st_r.smp))
        else $error("fall not preceded by high sample");

endmodule : tm2_edge_sampler

// >>> rtl/tm2_pkg.sv
package tm2_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'hc8;
    localparam logic [7:0] ADDR_MODE = 8'hc9;
    localparam logic [7:0] ADDR_CAPL = 8'hca;
    localparam logic [7:0] ADDR_CAPH = 8'hcb;
    localparam logic [7:0] ADDR_CNTL = 8'hcc;
    localparam logic [7:0] ADDR_CNTH = 8'hcd;

    // ------------------------------------------------------------
    // control and mode register fields
    // ------------------------------------------------------------
    localparam int BIT_OVF  = 7;
    localparam int BIT_EXF  = 6;
    localparam int BIT_RCLK = 5;
    localparam int BIT_TX_SERIAL_CLOCK_SELECT = 4;
    localparam int BIT_EXEN = 3;
    localparam int BIT_RUN  = 2;
    localparam int BIT_CT   = 1;
    localparam int BIT_CPRL = 0;
    localparam int BIT_DOWN_COUNT_ENABLE = 0;

    // ------------------------------------------------------------
    // reset values and count top
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_CTRL = 8'h00;
    localparam logic        RST_DOWN_COUNT_ENABLE = 1'b0;
    localparam logic [15:0] RST_CAP  = 16'h0000;
    localparam logic [15:0] RST_CNT  = 16'h0000;
    localparam logic [15:0] CNT_TOP  = 16'hffff;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int OSC_PERIOD_NS  = 10;
    localparam int MCLK_PERIOD_NS = 10;
    localparam int MC_OSC_PERIODS = 12;
    localparam int MC_CYCLES      =
        (MC_OSC_PERIODS * OSC_PERIOD_NS) / MCLK_PERIOD_NS;
    localparam logic [3:0] SAMPLE_PHASE = 4'h9;
    localparam logic [3:0] UPDATE_PHASE = 4'h4;

    typedef enum logic [1:0] {
        MODE_OFF     = 2'b00,
        MODE_RELOAD  = 2'b01,
        MODE_CAPTURE = 2'b10,
        MODE_BAUD    = 2'b11
    } tm2_mode_type;

endpackage : tm2_pkg

// >>> rtl/tm2_timer.sv
`timescale 1ns/1ps
module tm2_timer
    import tm2_pkg::*;
#(
    parameter int MC_LEN = MC_CYCLES
)(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_bit_wr,
    input  wire logic [2:0] sfr_bit_sel,
    input  wire logic       sfr_bit_val,
    output logic      [7:0] sfr_rdata,
    // pins
    input  wire logic       count_input,
    input  wire logic       trigger_input,
    // interrupt
    input  wire logic       timer_int_enable,
    output logic            timer_irq,
    // serial clocking
    output logic            rx_clock_select,
    output logic            tx_clock_select,
    output logic            overflow_tick
);

    if (MC_LEN != MC_CYCLES || MC_LEN > 16) begin : g_chk
        $error("phase counter supports only the twelve-clock cycle");
    end
    localparam logic [3:0] MC_LAST = 4'(MC_LEN - 1);
    typedef struct packed {
        logic [7:0]  ctrl;
        logic        down_count_enable;
        logic [15:0] cap;
        logic [15:0] cnt;
        logic [3:0]  phase;
        logic        cnt_pend;
        logic        trg_pend;
        logic [7:0]  rdata;
        logic        irq;
        logic        ovf_tick;
    } tm2_state_type;

    tm2_state_type st_r;
    tm2_state_type st_nxt;
    tm2_mode_type  mode;
    tm2_edge_if cnt_if ();
    tm2_edge_if trg_if ();
    logic update_now;
    logic tick;
    logic trg_evt;
    logic down;
    logic at_top;
    logic set_ovf;
    logic set_exf;
    logic tog_exf;
    logic baud_ovf;
    logic wr_ctrl;

    // ------------------------------------------------------------
    // pin samplers
    // ------------------------------------------------------------
    assign cnt_if.strobe = (st_r.phase == SAMPLE_PHASE);
    assign trg_if.strobe = (st_r.phase == SAMPLE_PHASE);
    tm2_edge_sampler u_cnt_smp (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .pin       (count_input),
        .edge_port (cnt_if)
    );
    tm2_edge_sampler u_trg_smp (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .pin       (trigger_input),
        .edge_port (trg_if)
    );

    // ------------------------------------------------------------
    // mode decode and count events
    // ------------------------------------------------------------
    always_comb begin
        if (!st_r.ctrl[BIT_RUN]) begin
            mode = MODE_OFF;
        end else if (st_r.ctrl[BIT_RCLK] | st_r.ctrl[BIT_TX_SERIAL_CLOCK_SELECT]) begin
            mode = MODE_BAUD;
        end else if (st_r.ctrl[BIT_CPRL]) begin
            mode = MODE_CAPTURE;
        end else begin
            mode = MODE_RELOAD;
        end
    end
    assign update_now = (st_r.phase == UPDATE_PHASE);
    assign at_top     = (st_r.cnt == CNT_TOP);
    assign trg_evt    = update_now & st_r.trg_pend
                      & st_r.ctrl[BIT_EXEN];
    assign down       = (mode == MODE_RELOAD) & st_r.down_count_enable
                      & ~trg_if.level;
    always_comb begin
        case (mode)
            MODE_OFF: begin
                tick = 1'b0;
            end
            MODE_BAUD: begin
                // timer function steps every state time here
                tick = st_r.ctrl[BIT_CT] ? (update_now & st_r.cnt_pend)
                                         : ~st_r.phase[0];
            end
            MODE_RELOAD, MODE_CAPTURE: begin
                tick = st_r.ctrl[BIT_CT] ? (update_now & st_r.cnt_pend)
                                         : update_now;
            end
            default: begin
                tick = 1'b0;
            end
        endcase
    end
    assign wr_ctrl = sfr_wr & (sfr_addr == ADDR_CTRL);
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt   = st_r;
        set_ovf  = 1'b0;
        set_exf  = 1'b0;
        tog_exf  = 1'b0;
        baud_ovf = 1'b0;
        st_nxt.phase = (st_r.phase == MC_LAST) ? 4'h0
                                               : st_r.phase + 4'h1;
        // a fall seen at sample phase waits for the next update phase
        if (cnt_if.fall) begin
            st_nxt.cnt_pend = 1'b1;
        end else if (update_now) begin
            st_nxt.cnt_pend = 1'b0;
        end
        if (trg_if.fall) begin
            st_nxt.trg_pend = 1'b1;
        end else if (update_now) begin
            st_nxt.trg_pend = 1'b0;
        end
        case (mode)
            MODE_RELOAD: begin
                if (st_r.down_count_enable) begin
                    if (tick && down) begin
                        if (st_r.cnt == st_r.cap) begin
                            st_nxt.cnt = CNT_TOP;
                            set_ovf    = 1'b1;
                            tog_exf    = 1'b1;
                        end else begin
                            st_nxt.cnt = st_r.cnt - 16'h0001;
                        end
                    end else if (tick) begin
                        st_nxt.cnt = at_top ? st_r.cap
                                            : st_r.cnt + 16'h0001;
                        set_ovf    = at_top;
                        tog_exf    = at_top;
                    end
                end else begin
                    if (tick) begin
                        st_nxt.cnt = at_top ? st_r.cap
                                            : st_r.cnt + 16'h0001;
                        set_ovf    = at_top;
                    end
                    if (trg_evt) begin
                        st_nxt.cnt = st_r.cap;
                        set_exf    = 1'b1;
                    end
                end
            end
            MODE_CAPTURE: begin
                if (tick) begin
                    st_nxt.cnt = st_r.cnt + 16'h0001;
                    set_ovf    = at_top;
                end
                if (trg_evt) begin
                    st_nxt.cap = st_r.cnt;
                    set_exf    = 1'b1;
                end
            end
            MODE_BAUD: begin
                if (tick) begin
                    st_nxt.cnt = at_top ? st_r.cap : st_r.cnt + 16'h0001;
                    baud_ovf   = at_top;
                end
                if (trg_evt) begin
                    set_exf = 1'b1;
                end
            end
            default: begin
            end
        endcase
        // software writes to count, capture and mode bytes
        if (sfr_wr) begin
            case (sfr_addr)
                ADDR_CNTL: st_nxt.cnt[7:0]  = sfr_wdata;
                ADDR_CNTH: st_nxt.cnt[15:8] = sfr_wdata;
                ADDR_CAPL: st_nxt.cap[7:0]  = sfr_wdata;
                ADDR_CAPH: st_nxt.cap[15:8] = sfr_wdata;
                ADDR_MODE: st_nxt.down_count_enable      = sfr_wdata[BIT_DOWN_COUNT_ENABLE];
                default: begin
                end
            endcase
        end
        if (tog_exf) begin
            st_nxt.ctrl[BIT_EXF] = ~st_r.ctrl[BIT_EXF];
        end
        if (wr_ctrl) begin
            st_nxt.ctrl = sfr_wdata;
        end
        if (sfr_bit_wr && sfr_addr == ADDR_CTRL) begin
            st_nxt.ctrl[sfr_bit_sel] = sfr_bit_val;
        end
        if (set_ovf) begin
            st_nxt.ctrl[BIT_OVF] = 1'b1;
        end
        if (set_exf) begin
            st_nxt.ctrl[BIT_EXF] = 1'b1;
        end
        st_nxt.ovf_tick = baud_ovf;
        st_nxt.irq = timer_int_enable
                   & (st_nxt.ctrl[BIT_OVF]
                   | (st_nxt.ctrl[BIT_EXF] & ~st_nxt.down_count_enable));
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_CTRL: st_nxt.rdata = st_r.ctrl;
                ADDR_MODE: st_nxt.rdata = {7'h00, st_r.down_count_enable};
                ADDR_CAPL: st_nxt.rdata = st_r.cap[7:0];
                ADDR_CAPH: st_nxt.rdata = st_r.cap[15:8];
                ADDR_CNTL: st_nxt.rdata = st_r.cnt[7:0];
                ADDR_CNTH: st_nxt.rdata = st_r.cnt[15:8];
                default:   st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r          <= '0;
            st_r.ctrl     <= RST_CTRL;
            st_r.down_count_enable     <= RST_DOWN_COUNT_ENABLE;
            st_r.cap      <= RST_CAP;
            st_r.cnt      <= RST_CNT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sfr_rdata       = st_r.rdata;
    assign timer_irq       = st_r.irq;
    assign rx_clock_select = st_r.ctrl[BIT_RCLK];
    assign tx_clock_select = st_r.ctrl[BIT_TX_SERIAL_CLOCK_SELECT];
    assign overflow_tick   = st_r.ovf_tick;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_PHASE_WRAP: assert property (
        st_r.phase == MC_LAST |=> st_r.phase == 4'h0 ##4
        st_r.phase == UPDATE_PHASE)
        else $error("machine cycle length wrong");
    AST_TIMER_RATE: assert property (
        mode == MODE_CAPTURE && !st_r.ctrl[BIT_CT] && update_now
        && !at_top && !sfr_wr && !trg_evt
        |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
        else $error("timer did not step at update phase");
    AST_STOPPED: assert property (
        mode == MODE_OFF && !sfr_wr |=> $stable(st_r.cnt))
        else $error("count moved while stopped");
    AST_COUNT_PHASE: assert property (
        st_r.ctrl[BIT_CT] && !sfr_wr && !update_now |=> $stable(st_r.cnt))
        else $error("count changed outside update phase");
    AST_NO_OVF_BAUD: assert property (
        mode == MODE_BAUD && !st_r.ctrl[BIT_OVF] && !sfr_wr && !sfr_bit_wr
        |=> !st_r.ctrl[BIT_OVF])
        else $error("overflow flag set in baud mode");
    AST_OVF_SET: assert property (
        tick && at_top && mode != MODE_BAUD && !down
        |=> st_r.ctrl[BIT_OVF])
        else $error("overflow flag missed");
    AST_CAPTURE: assert property (
        mode == MODE_CAPTURE && trg_evt && !sfr_wr
        |=> st_r.cap == $past(st_r.cnt) && st_r.ctrl[BIT_EXF])
        else $error("capture did not copy count");
    AST_RELOAD: assert property (
        mode != MODE_CAPTURE && mode != MODE_OFF && !st_r.down_count_enable
        && tick && at_top && !sfr_wr
        |=> st_r.cnt == $past(st_r.cap))
        else $error("overflow did not reload");
    AST_EXEN_OFF: assert property (
        !st_r.ctrl[BIT_EXEN] && !st_r.ctrl[BIT_EXF] && !st_r.down_count_enable
        && !sfr_wr && !sfr_bit_wr |=> !st_r.ctrl[BIT_EXF])
        else $error("trigger acted while disabled");
    AST_IRQ: assert property (
        ##1 timer_irq == ($past(timer_int_enable) && (st_r.ctrl[BIT_OVF]
        || (st_r.ctrl[BIT_EXF] && !st_r.down_count_enable))))
        else $error("interrupt request mismatch");
    AST_SET_WINS: assert property (
        set_ovf && wr_ctrl |=> st_r.ctrl[BIT_OVF])
        else $error("software clear beat hardware set");

    COV_CAPTURE:  cover property (mode == MODE_CAPTURE && trg_evt);
    COV_RELOAD:   cover property (mode == MODE_RELOAD && tick && at_top);
    COV_BAUD:     cover property (mode == MODE_BAUD && baud_ovf);
    COV_COUNTER:  cover property (st_r.ctrl[BIT_CT] && tick);

endmodule : tm2_timer

// >>> sim/timer2_capture_reload_counter_bench.sv
`timescale 1ns/1ps
module timer2_capture_reload_counter_bench;
    import tm2_pkg::*;
    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } tm2_row_type;

    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_wr = 1'b0;
    logic       sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_bit_wr = 1'b0;
    logic [2:0] sfr_bit_sel = 3'h0;
    logic       sfr_bit_val = 1'b0;
    logic [7:0] sfr_rdata;
    logic       count_input;
    logic       trigger_input;
    logic       timer_int_enable = 1'b1;
    logic       timer_irq;
    logic       rx_clock_select;
    logic       tx_clock_select;
    logic       overflow_tick;
    int         n_fail = 0;
    int         n_compared = 0;
    logic [7:0] d;
    logic [7:0] d0;
    int         ticks;
    tm2_row_type rows [9] = '{
        '{ADDR_CAPL, 8'h5a, 8'h5a}, '{ADDR_CAPH, 8'ha5, 8'ha5},
        '{ADDR_CNTL, 8'h3c, 8'h3c}, '{ADDR_CNTH, 8'hc3, 8'hc3},
        '{ADDR_MODE, 8'hff, 8'h01}, '{8'hce, 8'h55, 8'h00},
        '{ADDR_CTRL, 8'h03, 8'h03}, '{ADDR_MODE, 8'h00, 8'h00},
        '{ADDR_CTRL, 8'h00, 8'h00}};

    always #5 mclk = ~mclk;

    tm2_timer #(.MC_LEN(MC_CYCLES)) tm2_timer_i (
        .mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
        .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata),
        .count_input(count_input), .trigger_input(trigger_input),
        .timer_int_enable(timer_int_enable), .timer_irq(timer_irq),
        .rx_clock_select(rx_clock_select),
        .tx_clock_select(tx_clock_select),
        .overflow_tick(overflow_tick));

    tm2_pin_model tm2_pin_model_i (
        .mclk(mclk), .count_input(count_input),
        .trigger_input(trigger_input));

    // ------------------------------------------------------------
    // register access and checking
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        sfr_addr  <= a;
        sfr_wdata <= v;
        sfr_wr    <= 1'b1;
        @(posedge mclk);
        sfr_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge mclk);
        sfr_rd   <= 1'b0;
        @(posedge mclk);
        #1 v = sfr_rdata;
    endtask : rd

    task automatic bw(input logic [2:0] b, input logic v);
        @(posedge mclk);
        sfr_addr    <= ADDR_CTRL;
        sfr_bit_sel <= b;
        sfr_bit_val <= v;
        sfr_bit_wr  <= 1'b1;
        @(posedge mclk);
        sfr_bit_wr  <= 1'b0;
    endtask : bw

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        final_report();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, d);
            check("reg_rw", d, rows[i].rexp);
        end
        // reset in mid-run over written count and capture
        rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        check("irq_rst", timer_irq, 16'h0);
        check("tick_rst", overflow_tick, 16'h0);
        for (int a = 8'hc8; a <= 8'hce; a++) begin
            rd(a[7:0], d);
            check("reset_reg", d, 16'h0000);
        end
        // timer function rate and stop
        wr(ADDR_CNTL, 8'h00);
        wr(ADDR_CNTH, 8'h00);
        wr(ADDR_CTRL, 8'h04);
        rd(ADDR_CNTL, d0);
        repeat (117) @(posedge mclk);
        rd(ADDR_CNTL, d);
        check("timer_rate", d - d0, 16'h000a);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_CNTL, d0);
        repeat (60) @(posedge mclk);
        rd(ADDR_CNTL, d);
        check("stopped", d, d0);
        // counter function
        wr(ADDR_CNTL, 8'h00);
        wr(ADDR_CTRL, 8'h06);
        tm2_pin_model_i.count_falls(5);
        repeat (48) @(posedge mclk);
        rd(ADDR_CNTL, d);
        check("event_count", d, 16'h0005);
        // capture with trigger enabled
        wr(ADDR_CNTH, 8'h05);
        wr(ADDR_CTRL, 8'h0d);
        tm2_pin_model_i.trigger_fall();
        repeat (36) @(posedge mclk);
        rd(ADDR_CTRL, d);
        check("ext_flag", d, 16'h004d);
        check("irq_ext", timer_irq, 16'h1);
        bw(3'h2, 1'b0);
        rd(ADDR_CAPH, d);
        check("capture_high", d, 16'h0005);
        bw(3'h6, 1'b0);
        repeat (3) @(posedge mclk);
        check("irq_clr", timer_irq, 16'h0);
        // trigger ignored without enable
        wr(ADDR_CNTH, 8'h07);
        wr(ADDR_CTRL, 8'h05);
        tm2_pin_model_i.trigger_fall();
        repeat (36) @(posedge mclk);
        rd(ADDR_CTRL, d);
        check("no_trigger", d, 16'h0005);
        rd(ADDR_CAPH, d);
        check("no_capture", d, 16'h0005);
        // capture mode overflow
        wr(ADDR_CNTL, 8'hfe);
        wr(ADDR_CNTH, 8'hff);
        repeat (48) @(posedge mclk);
        rd(ADDR_CTRL, d);
        check("ovf_flag", d, 16'h0085);
        check("irq_ovf", timer_irq, 16'h1);
        timer_int_enable <= 1'b0;
        repeat (3) @(posedge mclk);
        check("irq_masked", timer_irq, 16'h0);
        bw(3'h2, 1'b0);
        rd(ADDR_CNTH, d);
        check("wrap", d, 16'h0000);
        bw(3'h7, 1'b0);
        timer_int_enable <= 1'b1;
        repeat (3) @(posedge mclk);
        check("irq_sw_clr", timer_irq, 16'h0);
        rd(ADDR_CTRL, d);
        check("ovf_clr", d, 16'h0001);
        // auto-reload on overflow
        wr(ADDR_CAPL, 8'h34);
        wr(ADDR_CAPH, 8'h12);
        wr(ADDR_CNTL, 8'hff);
        wr(ADDR_CNTH, 8'hff);
        wr(ADDR_CTRL, 8'h04);
        repeat (48) @(posedge mclk);
        bw(3'h2, 1'b0);
        rd(ADDR_CTRL, d);
        check("reload_ovf", d, 16'h0080);
        rd(ADDR_CNTH, d);
        check("reload_val", d, 16'h0012);
        // baud rate generator
        wr(ADDR_CAPL, 8'hf0);
        wr(ADDR_CAPH, 8'hff);
        wr(ADDR_CNTL, 8'hf0);
        wr(ADDR_CNTH, 8'hff);
        wr(ADDR_CTRL, 8'h24);
        ticks = 0;
        repeat (320) begin
            @(posedge mclk);
            if (overflow_tick === 1'b1) ticks++;
        end
        check("baud_ticks", ticks >= 9 && ticks <= 11, 16'h1);
        check("rx_sel", rx_clock_select, 16'h1);
        check("tx_sel_off", tx_clock_select, 16'h0);
        rd(ADDR_CTRL, d);
        check("baud_no_ovf", d, 16'h0024);
        wr(ADDR_CTRL, 8'h1c);
        tm2_pin_model_i.trigger_fall();
        repeat (36) @(posedge mclk);
        check("tx_sel", tx_clock_select, 16'h1);
        check("rx_sel_off", rx_clock_select, 16'h0);
        rd(ADDR_CTRL, d);
        check("baud_ext", d, 16'h005c);
        wr(ADDR_CTRL, 8'h00);
        // reload by trigger edge
        wr(ADDR_CAPL, 8'h00);
        wr(ADDR_CAPH, 8'h40);
        wr(ADDR_CNTH, 8'h00);
        wr(ADDR_CTRL, 8'h0c);
        tm2_pin_model_i.trigger_fall();
        bw(3'h2, 1'b0);
        rd(ADDR_CNTH, d);
        check("trig_reload", d, 16'h0040);
        rd(ADDR_CTRL, d);
        check("reload_ext", d, 16'h0048);
        // down counting steered by the trigger level
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_CAPH, 8'h00);
        wr(ADDR_CNTL, 8'h02);
        wr(ADDR_CNTH, 8'h00);
        wr(ADDR_MODE, 8'h01);
        tm2_pin_model_i.trigger_level(1'b0);
        repeat (24) @(posedge mclk);
        wr(ADDR_CTRL, 8'h04);
        repeat (40) @(posedge mclk);
        bw(3'h2, 1'b0);
        rd(ADDR_CTRL, d);
        check("down_flags", d, 16'h00c0);
        rd(ADDR_CNTH, d);
        check("down_wrap", d, 16'h00ff);
        check("irq_down_ovf", timer_irq, 16'h1);
        bw(3'h7, 1'b0);
        repeat (3) @(posedge mclk);
        check("irq_no_ext", timer_irq, 16'h0);
        tm2_pin_model_i.trigger_level(1'b1);
        wr(ADDR_MODE, 8'h00);
        final_report();
    end
endmodule : timer2_capture_reload_counter_bench

// >>> sim/tm2_pin_model.sv
`timescale 1ns/1ps
module tm2_pin_model (
    // clock
    input  wire logic mclk,
    // pins, idle high like pulled-up port lines
    output logic      count_input,
    output logic      trigger_input
);
    // every level of a count or trigger pulse lasts two machine cycles
    localparam int HOLD = 24;

    initial begin
        count_input   = 1'b1;
        trigger_input = 1'b1;
    end

    task automatic count_falls(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            count_input <= 1'b0;
            repeat (HOLD) @(posedge mclk);
            count_input <= 1'b1;
            repeat (HOLD - 1) @(posedge mclk);
        end
    endtask : count_falls

    task automatic trigger_fall();
        @(posedge mclk);
        trigger_input <= 1'b0;
        repeat (HOLD) @(posedge mclk);
        trigger_input <= 1'b1;
        repeat (HOLD) @(posedge mclk);
    endtask : trigger_fall

    task automatic trigger_level(input logic v);
        @(posedge mclk);
        trigger_input <= v;
    endtask : trigger_level
endmodule : tm2_pin_model
